// ===== ofc_host_model.sv
// Host receiver model: run lengths and rising edges of one observed status pin
`timescale 1ns/10ps
module ofc_host_model (
  // Clock and reset
  input  wire logic   clock,
  input  wire logic   rst_n,
  // Observed pin
  input  wire logic   line_in,
  // Measurements
  output logic [7:0]  high_len,
  output logic [7:0]  low_len,
  output logic [15:0] rises
);
  logic       prev;
  logic [7:0] run;

  // Sampled on the block clock, so a clock pin reads as whole-cycle runs
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prev     <= 1'b0;
      run      <= 8'h00;
      high_len <= 8'h00;
      low_len  <= 8'h00;
      rises    <= 16'h0000;
    end else begin
      prev <= line_in;
      if (line_in != prev) begin
        run <= 8'h01;
        if (prev) begin
          high_len <= run;
        end else begin
          low_len <= run;
        end
      end else begin
        run <= run + 8'h01;
      end
      if (line_in && !prev) begin
        rises <= rises + 16'h0001;
      end
    end
  end
endmodule

// ===== ofc_params.svh
// Register offsets, field positions, reset values and codes of the range flag / clock out block
`ifndef OFC_PARAMS_SVH
`define OFC_PARAMS_SVH

`define OFC_ADDR_CTRL      8'h00
`define OFC_ADDR_THRESH    8'h04
`define OFC_ADDR_HOLD      8'h08
`define OFC_ADDR_STATUS    8'h0c
`define OFC_ADDR_MASK      8'h10
`define OFC_ADDR_STATE     8'h14
`define OFC_ADDR_COUNT_A   8'h18
`define OFC_ADDR_STRIDE    8'h04

`define OFC_CTRL_OVR_BIT   0
`define OFC_CTRL_DIS_BIT   1
`define OFC_CTRL_SEL_LSB   2

`define OFC_STAT_SEL_BIT   3

`define OFC_THRESH_RESET   12'hc00
`define OFC_HOLD_RESET     8'h08
`define OFC_MASK_RESET     4'h0
`define OFC_COUNT_MAX      16'hffff

`define OFC_VAR_ONE        2'h0
`define OFC_VAR_TWO        2'h1
`define OFC_VAR_FOUR       2'h2

`endif

// ===== ofc_pkg.sv
// Types shared by the range flag / clock out block
package ofc_pkg;
  typedef enum logic [1:0] {
    OFC_SEL_FLAG,
    OFC_SEL_REF,
    OFC_SEL_DIV2,
    OFC_SEL_DIV4
  } ofc_clk_sel_t;

  typedef logic [11:0] ofc_sample_t;
  typedef logic [7:0]  ofc_hold_t;
  typedef logic [1:0]  ofc_variant_t;
endpackage

// ===== ofc_range_clock_out.sv
// Over-range flag outputs with clock-out option on channel C, APB registers and interrupt
//
// What this block does
// - Channel A flag output goes high whenever the channel A sample exceeds the threshold setting outside power-down.
// - Every asserted flag stays high for at least the programmed minimum hold length while its channel stays enabled.
// - Channel B flag output goes high whenever the channel B sample exceeds the threshold setting and channel B is enabled.
// - Channel B detection works only in four- and two-channel variants; the one-channel part keeps it low.
// - Channel C detection exists only in the four-channel variant and drives the C output when no clock is chosen.
// - The C output carries a clock only when the selection picks one and the PLL enable strap is high.
// - With both selection bits low, or the clock disabled by register, the C output carries the C flag.
// - Selection 1 gives the reference copy, 2 the reference divided by two, 3 divided by four.
// - The strap-selected clock appears from reset without any register write.
// - Power-down stops the reference output and any clock on the C output.
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
`include "ofc_params.svh"
module ofc_range_clock_out
  import ofc_pkg::*;
(
  // Clock and reset
  input  wire logic   clock,
  input  wire logic   rst_n,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Channel samples (magnitude)
  input  wire logic        sample_valid,
  input  ofc_sample_t      sample_a,
  input  ofc_sample_t      sample_b,
  input  ofc_sample_t      sample_c,
  // Straps and power down
  input  wire logic        pll_enable_strap,
  input  wire logic [1:0]  clock_out_select,
  input  ofc_variant_t     variant_strap,
  input  wire logic        power_down_pin,
  // Pin outputs
  output logic             range_flag_a,
  output logic             range_flag_b,
  output logic             range_flag_or_clock_c,
  output logic             synth_ref_output,
  // Interrupt
  output logic             irq
);
  logic         ctrl_override;
  logic         ctrl_disable;
  logic [1:0]   ctrl_sel;
  ofc_sample_t  overrange_threshold;
  ofc_hold_t    overrange_min_hold;
  logic [3:0]   status;
  logic [3:0]   mask;
  logic [15:0]  event_count [3];
  logic [2:0]   ref_cnt;
  logic [2:0]   next_ref_cnt;
  logic [2:0]   chan_en;
  logic [2:0]   flag;
  logic [2:0]   flag_q;
  logic [3:0]   next_set;
  ofc_sample_t  samples [3];
  ofc_clk_sel_t cur_sel;
  ofc_clk_sel_t prev_sel;
  logic         next_out_c;
  logic         access;
  logic         wr_access;
  logic         rd_access;
  logic [31:0]  rd_word;
  logic [3:0]   div4_steady;

  // Effective clock-out choice from straps, register override and PLL strap
  function automatic ofc_clk_sel_t pick_sel(input logic ovr, input logic dis, input logic pll,
                                            input logic [1:0] reg_sel, input logic [1:0] strap_sel);
    logic [1:0] raw;
    raw = ovr ? reg_sel : strap_sel;
    if (dis || !pll || raw == 2'h0) begin
      pick_sel = OFC_SEL_FLAG;
    end else begin
      pick_sel = ofc_clk_sel_t'(raw);
    end
  endfunction

  function automatic logic [7:0] count_addr(input logic [1:0] idx);
    count_addr = `OFC_ADDR_COUNT_A + 8'(idx) * `OFC_ADDR_STRIDE;
  endfunction

  function automatic logic reg_hit(input logic [7:0] addr);
    reg_hit = addr == `OFC_ADDR_CTRL || addr == `OFC_ADDR_THRESH || addr == `OFC_ADDR_HOLD ||
              addr == `OFC_ADDR_STATUS || addr == `OFC_ADDR_MASK || addr == `OFC_ADDR_STATE ||
              addr == count_addr(2'h0) || addr == count_addr(2'h1) || addr == count_addr(2'h2);
  endfunction

  // APB handshake: one wait state, answer registered
  assign access    = psel && penable && pready;
  assign wr_access = access && pwrite && !pslverr;
  assign rd_access = access && !pwrite && !pslverr;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    case (paddr)
      `OFC_ADDR_CTRL: begin
        rd_word[`OFC_CTRL_OVR_BIT]                       = ctrl_override;
        rd_word[`OFC_CTRL_DIS_BIT]                       = ctrl_disable;
        rd_word[`OFC_CTRL_SEL_LSB +: 2]                  = ctrl_sel;
      end
      `OFC_ADDR_THRESH: rd_word[11:0] = overrange_threshold;
      `OFC_ADDR_HOLD:   rd_word[7:0]  = overrange_min_hold;
      `OFC_ADDR_STATUS: rd_word[3:0]  = status;
      `OFC_ADDR_MASK:   rd_word[3:0]  = mask;
      `OFC_ADDR_STATE:  rd_word[11:0] = {variant_strap, power_down_pin, pll_enable_strap,
                                         clock_out_select, cur_sel, 1'b0, flag};
      default: begin
        if (paddr == count_addr(2'h0)) begin
          rd_word[15:0] = event_count[0];
        end else if (paddr == count_addr(2'h1)) begin
          rd_word[15:0] = event_count[1];
        end else if (paddr == count_addr(2'h2)) begin
          rd_word[15:0] = event_count[2];
        end
      end
    endcase
  end

  // Read data sampled one cycle before the access edge
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_word;
      pslverr <= !reg_hit(paddr);
    end
  end

  // Control registers; reset leaves the straps in charge
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_override <= 1'b0;
      ctrl_disable  <= 1'b0;
      ctrl_sel      <= 2'h0;
    end else if (wr_access && paddr == `OFC_ADDR_CTRL) begin
      ctrl_override <= pwdata[`OFC_CTRL_OVR_BIT];
      ctrl_disable  <= pwdata[`OFC_CTRL_DIS_BIT];
      ctrl_sel      <= pwdata[`OFC_CTRL_SEL_LSB +: 2];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      overrange_threshold <= `OFC_THRESH_RESET;
      overrange_min_hold  <= `OFC_HOLD_RESET;
      mask                <= `OFC_MASK_RESET;
    end else if (wr_access) begin
      if (paddr == `OFC_ADDR_THRESH) begin
        overrange_threshold <= pwdata[11:0];
      end
      if (paddr == `OFC_ADDR_HOLD) begin
        overrange_min_hold <= pwdata[7:0];
      end
      if (paddr == `OFC_ADDR_MASK) begin
        mask <= pwdata[3:0];
      end
    end
  end

  // Channel enables follow the variant strap; power down silences all
  always_comb begin
    chan_en[0] = !power_down_pin;
    chan_en[1] = !power_down_pin && variant_strap != `OFC_VAR_ONE;
    chan_en[2] = !power_down_pin && variant_strap == `OFC_VAR_FOUR;
  end

  assign samples[0] = sample_a;
  assign samples[1] = sample_b;
  assign samples[2] = sample_c;

  generate
    for (genvar i = 0; i < 3; i++) begin : g_chan
      ofc_range_detect u_detect (
        .clock        (clock),
        .rst_n        (rst_n),
        .enable       (chan_en[i]),
        .sample_valid (sample_valid),
        .sample       (samples[i]),
        .threshold    (overrange_threshold),
        .min_hold     (overrange_min_hold),
        .flag         (flag[i])
      );

      // Saturating count of flag rising edges; a write clears, a new event still counts
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          event_count[i] <= 16'h0000;
        end else if (wr_access && paddr == count_addr(2'(i))) begin
          event_count[i] <= {15'h0000, next_set[i]};
        end else if (next_set[i] && event_count[i] != `OFC_COUNT_MAX) begin
          event_count[i] <= event_count[i] + 16'h0001;
        end
      end
    end
  endgenerate

  // Event detection and sticky status
  assign cur_sel  = pick_sel(ctrl_override, ctrl_disable, pll_enable_strap, ctrl_sel, clock_out_select);
  assign next_set = {cur_sel != prev_sel, flag & ~flag_q};

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flag_q   <= 3'h0;
      prev_sel <= cur_sel; // Straps live in reset, so no false change event after it
    end else begin
      flag_q   <= flag;
      prev_sel <= cur_sel;
    end
  end

  // Read clears only the bits that were returned, so a late event survives
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      status <= 4'h0;
    end else if (rd_access && paddr == `OFC_ADDR_STATUS) begin
      status <= (status & ~prdata[3:0]) | next_set;
    end else begin
      status <= status | next_set;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  // Reference model: free-running counter, phase restarts after power down
  assign next_ref_cnt = power_down_pin ? 3'h0 : ref_cnt + 3'h1;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ref_cnt <= 3'h0;
    end else begin
      ref_cnt <= next_ref_cnt;
    end
  end

  always_comb begin
    case (cur_sel)
      OFC_SEL_FLAG: next_out_c = flag[2];
      OFC_SEL_REF:  next_out_c = next_ref_cnt[0];
      OFC_SEL_DIV2: next_out_c = next_ref_cnt[1];
      OFC_SEL_DIV4: next_out_c = next_ref_cnt[2];
      default:      next_out_c = flag[2];
    endcase
    if (power_down_pin && cur_sel != OFC_SEL_FLAG) begin
      next_out_c = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      range_flag_a          <= 1'b0;
      range_flag_b          <= 1'b0;
      range_flag_or_clock_c <= 1'b0;
      synth_ref_output      <= 1'b0;
    end else begin
      range_flag_a          <= flag[0];
      range_flag_b          <= flag[1];
      range_flag_or_clock_c <= next_out_c;
      synth_ref_output      <= !power_down_pin && next_ref_cnt[0];
    end
  end

  // Helper for the divider check only
  always_ff @(posedge clock) begin
    if (!rst_n || cur_sel != OFC_SEL_DIV4 || power_down_pin) begin
      div4_steady <= 4'h0;
    end else if (div4_steady != 4'hf) begin
      div4_steady <= div4_steady + 4'h1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_exceed_a;
    sample_valid && !power_down_pin && sample_a > overrange_threshold;
  endsequence

  sequence s_exceed_b;
    sample_valid && chan_en[1] && sample_b > overrange_threshold;
  endsequence

  // Looks back from a fall, so a selection change right after a rise is not flagged
  sequence s_div4_fall;
    range_flag_or_clock_c ##1 (!range_flag_or_clock_c && div4_steady > 4'h8);
  endsequence

  a_flag_a_set: assert property (s_exceed_a ##1 !power_down_pin |=> range_flag_a)
    else $error("Channel A flag missing after exceed");

  a_flag_b_set: assert property (s_exceed_b ##1 chan_en[1] |=> range_flag_b)
    else $error("Channel B flag missing after exceed");

  a_flag_b_off: assert property ((variant_strap == `OFC_VAR_ONE) [*3] |-> !range_flag_b)
    else $error("Channel B flag active in one-channel variant");

  a_flag_c_off: assert property
    ((variant_strap != `OFC_VAR_FOUR && cur_sel == OFC_SEL_FLAG) [*3] |-> !range_flag_or_clock_c)
    else $error("Channel C flag active without four channels");

  a_sel_gate: assert property (!pll_enable_strap || ctrl_disable |-> cur_sel == OFC_SEL_FLAG)
    else $error("Clock chosen without PLL enable or while disabled");

  a_flag_route: assert property (cur_sel == OFC_SEL_FLAG |=> range_flag_or_clock_c == $past(flag[2]))
    else $error("Channel C output does not follow its flag");

  a_strap_boot: assert property
    (!ctrl_override && !ctrl_disable && pll_enable_strap |-> cur_sel == ofc_clk_sel_t'(clock_out_select))
    else $error("Strap selection not applied");

  a_ref_copy: assert property
    ((cur_sel == OFC_SEL_REF && !power_down_pin) [*2] |-> range_flag_or_clock_c != $past(range_flag_or_clock_c))
    else $error("Reference copy not toggling");

  a_powerdown_quiet: assert property
    (power_down_pin && cur_sel != OFC_SEL_FLAG |=> !range_flag_or_clock_c && !synth_ref_output)
    else $error("Clock still driven in power down");

  a_div4_shape: assert property
    (s_div4_fall |-> $past(range_flag_or_clock_c, 2) && $past(range_flag_or_clock_c, 3) &&
                     $past(range_flag_or_clock_c, 4) && !$past(range_flag_or_clock_c, 5))
    else $error("Divide-by-four clock not four high, then low");

  a_irq_level: assert property ((|(status & mask)) [*2] |-> irq)
    else $error("Interrupt low with unmasked status set");

  a_apb_answer: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("APB answer not one cycle wide after one wait");
endmodule

// ===== ofc_range_detect.sv
// One channel over-range detector with minimum hold time
`timescale 1ns/10ps
module ofc_range_detect
  import ofc_pkg::*;
(
  // Clock and reset
  input  wire logic  clock,
  input  wire logic  rst_n,
  // Channel data and settings
  input  wire logic  enable,
  input  wire logic  sample_valid,
  input  ofc_sample_t sample,
  input  ofc_sample_t threshold,
  input  ofc_hold_t   min_hold,
  // Result
  output logic        flag
);
  ofc_hold_t hold_cnt;
  ofc_hold_t high_len;
  logic      exceed;

  assign exceed = enable && sample_valid && (sample > threshold);

  // Every new exceed restarts the hold window
  always_ff @(posedge clock) begin
    if (!rst_n || !enable) begin
      flag     <= 1'b0;
      hold_cnt <= '0;
    end else if (exceed) begin
      flag     <= 1'b1;
      hold_cnt <= min_hold;
    end else if (hold_cnt > 8'h01) begin
      hold_cnt <= hold_cnt - 8'h01;
    end else begin
      flag     <= 1'b0;
      hold_cnt <= '0;
    end
  end

  // Helper for the hold check only
  always_ff @(posedge clock) begin
    if (!rst_n || !flag) begin
      high_len <= '0;
    end else if (high_len != 8'hff) begin
      high_len <= high_len + 8'h01;
    end
  end

  a_min_hold_len: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(flag) && enable && $past(enable) && $stable(min_hold)
      |-> ({1'b0, $past(high_len)} + 9'h001 >= {1'b0, min_hold}))
    else $error("Over-range flag dropped before its minimum hold");
endmodule

// ===== test_ofc_range_clock_out.sv
// Self-checking testbench of the range flag / clock out block
`timescale 1ns/10ps
`include "ofc_params.svh"
module test_ofc_range_clock_out;
  logic                 clock, rst_n, psel, penable, pwrite, pready, pslverr, er;
  logic                 sample_valid, pll_enable_strap, power_down_pin, irq, ref_q;
  logic                 range_flag_a, range_flag_b, range_flag_or_clock_c, synth_ref_output;
  logic [7:0]           paddr, hl_a, hl_c, ll_c;
  logic [31:0]          pwdata, prdata, rd;
  logic [1:0]           clock_out_select;
  ofc_pkg::ofc_variant_t variant_strap;
  ofc_pkg::ofc_sample_t  sample_a, sample_b, sample_c;
  logic [15:0]          ri_a, ri_b, ri_c, r0;
  int                   miscompares = 0;
  int                   num_checks = 0;
  int                   cycles = 0;

  ofc_range_clock_out dut_u (.clock(clock), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_valid(sample_valid), .sample_a(sample_a), .sample_b(sample_b), .sample_c(sample_c),
    .pll_enable_strap(pll_enable_strap), .clock_out_select(clock_out_select), .variant_strap(variant_strap),
    .power_down_pin(power_down_pin), .range_flag_a(range_flag_a), .range_flag_b(range_flag_b),
    .range_flag_or_clock_c(range_flag_or_clock_c), .synth_ref_output(synth_ref_output), .irq(irq));
  ofc_host_model host_a (.clock(clock), .rst_n(rst_n), .line_in(range_flag_a), .high_len(hl_a),
    .low_len(), .rises(ri_a));
  ofc_host_model host_b (.clock(clock), .rst_n(rst_n), .line_in(range_flag_b), .high_len(),
    .low_len(), .rises(ri_b));
  ofc_host_model host_c (.clock(clock), .rst_n(rst_n), .line_in(range_flag_or_clock_c), .high_len(hl_c),
    .low_len(ll_c), .rises(ri_c));

  task conclude();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Holds the request until pready is seen high at a rising edge
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk(n < 20, 1'b1, "apb answer");
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task pulse(input int ch, input logic [11:0] v);
    sample_valid <= 1'b1;
    if (ch == 0) sample_a <= v;
    else if (ch == 1) sample_b <= v;
    else sample_c <= v;
    @(posedge clock);
    sample_valid <= 1'b0;
    sample_a     <= 12'h000;
    sample_b     <= 12'h000;
    sample_c     <= 12'h000;
    repeat (14) @(posedge clock);
  endtask

  task t_clock_sel();
    repeat (10) @(posedge clock);
    chk(hl_c, 1, "strap clock high");
    chk(ll_c, 1, "strap clock low");
    ref_q = synth_ref_output;
    @(posedge clock);
    chk(synth_ref_output, !ref_q, "ref runs");
    for (int s = 2; s < 4; s++) begin
      clock_out_select <= s[1:0];
      repeat (20) @(posedge clock);
      chk(hl_c, 32'h1 << (s - 1), "div clock high");
      chk(ll_c, 32'h1 << (s - 1), "div clock low");
    end
  endtask

  task t_regs();
    apb(`OFC_ADDR_THRESH, 1'b0, 32'h0000_0000);
    chk(rd, {20'h0_0000, `OFC_THRESH_RESET}, "thresh reset");
    apb(`OFC_ADDR_HOLD, 1'b0, 32'h0000_0000);
    chk(rd, {24'h00_0000, `OFC_HOLD_RESET}, "hold reset");
    apb(8'h40, 1'b0, 32'h0000_0000);
    chk(er, 1'b1, "unmapped error");
  endtask

  task t_flag_a();
    sample_a     <= 12'hc01;
    sample_valid <= 1'b1;
    @(posedge clock);
    sample_valid <= 1'b0;
    sample_a     <= 12'h000;
    @(posedge clock);
    chk(range_flag_a, 1'b0, "flag a early");
    @(posedge clock);
    chk(range_flag_a, 1'b1, "flag a up");
    repeat (12) @(posedge clock);
    chk(hl_a, 8, "hold 8");
    r0 = ri_a;
    pulse(0, 12'hc00);
    chk(ri_a, r0, "at threshold");
    apb(`OFC_ADDR_HOLD, 1'b1, 32'h0000_0003);
    pulse(0, 12'hfff);
    chk(hl_a, 3, "hold 3");
    apb(`OFC_ADDR_COUNT_A, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0002, "count a");
    apb(`OFC_ADDR_COUNT_A, 1'b1, 32'h0000_0000);
    apb(`OFC_ADDR_COUNT_A, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "count a clear");
  endtask

  task t_variant();
    clock_out_select <= 2'h0;
    variant_strap    <= `OFC_VAR_ONE;
    r0 = ri_b;
    pulse(1, 12'hfff);
    chk(ri_b, r0, "b one channel");
    variant_strap <= `OFC_VAR_TWO;
    pulse(1, 12'hfff);
    chk(ri_b, r0 + 16'h0001, "b two channel");
    r0 = ri_c;
    pulse(2, 12'hfff);
    chk(ri_c, r0, "c two channel");
    variant_strap <= `OFC_VAR_FOUR;
    pulse(2, 12'hfff);
    chk(ri_c, r0 + 16'h0001, "c four channel");
    apb(`OFC_ADDR_STATE, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0900, "state word");
  endtask

  task t_gate();
    clock_out_select <= 2'h3;
    pll_enable_strap <= 1'b0;
    repeat (4) @(posedge clock);
    r0 = ri_c;
    pulse(2, 12'hfff);
    chk(ri_c, r0 + 16'h0001, "pll off flag");
    pll_enable_strap <= 1'b1;
    apb(`OFC_ADDR_CTRL, 1'b1, 32'h0000_0002);
    repeat (4) @(posedge clock);
    r0 = ri_c;
    pulse(2, 12'hfff);
    chk(ri_c, r0 + 16'h0001, "disabled flag");
    apb(`OFC_ADDR_CTRL, 1'b1, 32'h0000_0009);
    repeat (20) @(posedge clock);
    chk(hl_c, 2, "reg sel div2");
    apb(`OFC_ADDR_CTRL, 1'b1, 32'h0000_0000);
  endtask

  task t_pdown();
    clock_out_select <= 2'h1;
    power_down_pin   <= 1'b1;
    repeat (3) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      chk(range_flag_or_clock_c, 1'b0, "powerdown c");
      chk(synth_ref_output, 1'b0, "powerdown ref");
    end
    power_down_pin <= 1'b0;
    repeat (20) @(posedge clock);
    chk(hl_c, 1, "clock back");
  endtask

  // Sel-change events stay masked, only the channel A bit drives irq
  task t_irq();
    apb(`OFC_ADDR_MASK, 1'b1, 32'h0000_0001);
    apb(`OFC_ADDR_STATUS, 1'b0, 32'h0000_0000);
    pulse(0, 12'hfff);
    chk(irq, 1'b1, "irq set");
    apb(`OFC_ADDR_STATUS, 1'b0, 32'h0000_0000);
    chk(rd[0], 1'b1, "status a");
    repeat (3) @(posedge clock);
    chk(irq, 1'b0, "irq cleared");
    apb(`OFC_ADDR_MASK, 1'b1, 32'h0000_0000);
    pulse(0, 12'hfff);
    chk(irq, 1'b0, "irq masked");
  endtask

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      $display("BAD %0t run too long", $time);
      conclude();
    end
  end

  initial begin
    rst_n            = 1'b0;
    psel             = 1'b0;
    penable          = 1'b0;
    pwrite           = 1'b0;
    paddr            = 8'h00;
    pwdata           = 32'h0000_0000;
    sample_valid     = 1'b0;
    sample_a         = 12'h000;
    sample_b         = 12'h000;
    sample_c         = 12'h000;
    pll_enable_strap = 1'b1;
    clock_out_select = 2'h1;
    variant_strap    = `OFC_VAR_FOUR;
    power_down_pin   = 1'b0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    t_clock_sel();
    t_regs();
    t_flag_a();
    t_variant();
    t_gate();
    t_pdown();
    t_irq();
    conclude();
  end
endmodule
